// [cswm_chk.sv]
// port assertions of the mode control channel
// assumes one clock, synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module cswm_chk (
  // clock and reset
  input wire logic                      sys_clk,
  input wire logic                      sys_rst,
  // register port
  input wire logic [3:0]                reg_addr,
  input wire logic                      reg_rd,
  input wire logic [15:0]               reg_rdata,
  // bus side
  input wire cswm_pkg::cswm_bus_ev_type bus_ev,
  input wire logic                      transmit_data_in,
  input wire logic                      bus_rx_level,
  input wire logic                      receive_data_out,
  input wire logic                      bus_tx_enable,
  input wire logic                      receive_enable,
  input wire logic                      can_wake_irq,
  input wire logic                      xcvr_woken
);
  localparam int YP = cswm_pkg::STAT_SYNC_POS;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ****
  // sequences
  // ****
  sequence s_rd_st;
    reg_rd && reg_addr == cswm_pkg::ADDR_STATUS;
  endsequence
  sequence s_frame;
    receive_enable && bus_ev.frame_valid && !bus_ev.proto_error ##1 !bus_ev.proto_error
      ##1 s_rd_st and !bus_ev.proto_error;
  endsequence
  sequence s_err;
    bus_ev.proto_error ##1 !bus_ev.frame_valid ##1 s_rd_st and !bus_ev.frame_valid;
  endsequence
  // ****
  // properties
  // ****
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 16'h0;
  endproperty
  property p_mode_hi;
    reg_rd && reg_addr == cswm_pkg::ADDR_MODE |=> reg_rdata[15:3] == 13'h0;
  endproperty
  property p_sync_set;
    s_frame |=> reg_rdata[YP];
  endproperty
  property p_sync_clr;
    s_err |=> !reg_rdata[YP];
  endproperty
  property p_tx_rx;
    !receive_enable |-> !bus_tx_enable;
  endproperty
  property p_tx_cause;
    bus_tx_enable |-> $past(transmit_data_in) == 1'b0;
  endproperty
  property p_rx_pass;
    receive_enable && $past(receive_enable) && $past(receive_enable, 2)
      |-> receive_data_out == $past(bus_rx_level);
  endproperty
  property p_rx_idle;
    !receive_enable && !$past(receive_enable) && !$past(receive_enable, 2) |-> receive_data_out;
  endproperty
  property p_irq_pulse;
    can_wake_irq |=> !can_wake_irq;
  endproperty
  property p_irq_cause;
    can_wake_irq |-> $past(bus_ev.wake_frame) || $past(bus_ev.wake_pattern) || $past(bus_ev.proto_error);
  endproperty
  property p_woken_cause;
    $rose(xcvr_woken) |-> $past(bus_ev.wake_frame) || $past(bus_ev.wake_pattern) || $past(bus_ev.proto_error);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
  a_mode_hi: assert property (p_mode_hi) else $error("mode read upper bits set");
  a_sync_set: assert property (p_sync_set) else $error("sync flag not set");
  a_sync_clr: assert property (p_sync_clr) else $error("sync flag not cleared");
  a_tx_rx: assert property (p_tx_rx) else $error("transmit without receive mode");
  a_tx_cause: assert property (p_tx_cause) else $error("transmit without request");
  a_rx_pass: assert property (p_rx_pass) else $error("receive data not passed");
  a_rx_idle: assert property (p_rx_idle) else $error("receive data not high");
  a_irq_pulse: assert property (p_irq_pulse) else $error("wake interrupt too long");
  a_irq_cause: assert property (p_irq_cause) else $error("wake interrupt without cause");
  a_woken_cause: assert property (p_woken_cause) else $error("woken without cause");
endmodule : cswm_chk

bind cswm_ctrl cswm_chk u_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .bus_ev(bus_ev), .transmit_data_in(transmit_data_in),
  .bus_rx_level(bus_rx_level), .receive_data_out(receive_data_out),
  .bus_tx_enable(bus_tx_enable), .receive_enable(receive_enable),
  .can_wake_irq(can_wake_irq), .xcvr_woken(xcvr_woken)
);
`default_nettype wire

// [cswm_ctrl.sv]
// mode control and status flags of one selective-wake transceiver channel
// bus events come from a same-clock frame decoder; registers over plain port
`timescale 1ns/1ps
`default_nettype none

module cswm_ctrl #(
  parameter int SILENCE_COUNT = cswm_pkg::SILENCE_CYCLES
) (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  // register port
  input  wire logic [3:0]               reg_addr,
  input  wire logic [15:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output var  logic [15:0]              reg_rdata,
  // bus events from decoder
  input  wire cswm_pkg::cswm_bus_ev_type bus_ev,
  input  wire logic                     transmit_data_in,
  input  wire logic                     bus_rx_level,
  // transceiver controls
  output var  logic                     receive_data_out,
  output var  logic                     bus_tx_enable,
  output var  logic                     receive_enable,
  output var  logic                     can_wake_irq,
  output var  logic                     xcvr_woken
);

  // ************************************************************
  // state
  // ************************************************************
  logic [2:0]                       mode;
  cswm_pkg::cswm_chip_type          chip;
  cswm_pkg::cswm_swk_state_type     swk_state;
  logic                             bus_silence_flag;
  logic                             frame_sync_flag;
  logic                             wake_armed_flag;
  logic                             selective_wake_fault_flag;
  logic [5:0]                       protocol_error_count;
  logic [31:0]                      silence_timer;
  logic                             xcvr_mode_bit0;
  logic                             xcvr_mode_bit1;
  logic                             xcvr_mode_bit2;
  logic                             enabled;
  logic                             swk_mode;
  logic                             swk_active;
  logic                             silence_expired;
  logic                             in_detect;
  logic                             ecnt_overflow;
  logic                             wake_event;
  logic                             mode_wr;
  logic                             chip_wr;
  logic                             to_stop;
  logic [2:0]                       next_mode;
  cswm_pkg::cswm_chip_type          next_chip;
  logic                             swk_arm_wr;
  logic                             wuf_wake;
  logic                             wup_wake;
  logic                             silence_restart;
  logic                             ecnt_clear;
  logic                             ecnt_freeze;
  logic                             fault_set;
  logic                             fault_clr_wr;
  logic                             armed_set;
  logic                             tx_mode;
  logic [15:0]                      status_word;

  // ************************************************************
  // mode decode
  // ************************************************************
  assign xcvr_mode_bit0 = mode[0];
  assign xcvr_mode_bit1 = mode[1];
  assign xcvr_mode_bit2 = mode[2];
  // off codes 000 and 100 leave both low bits clear
  assign enabled  = xcvr_mode_bit0 | xcvr_mode_bit1;
  assign swk_mode = xcvr_mode_bit2 & enabled;
  assign swk_active = swk_mode & ~selective_wake_fault_flag;
  assign in_detect = (swk_state == cswm_pkg::SW_WUF_DET) ||
                     (swk_state == cswm_pkg::SW_WUP_DET2);
  assign silence_expired = in_detect && (silence_timer >= 32'(SILENCE_COUNT - 1));
  assign ecnt_overflow = bus_ev.proto_error && (protocol_error_count == cswm_pkg::ECNT_MAX);
  assign mode_wr = reg_wr && (reg_addr == cswm_pkg::ADDR_MODE) &&
                   (chip == cswm_pkg::CHIP_NORMAL);
  assign chip_wr = reg_wr && (reg_addr == cswm_pkg::ADDR_CHIP);
  assign to_stop = chip_wr && (chip == cswm_pkg::CHIP_NORMAL) &&
                   (reg_wdata[1:0] == 2'h1);

  // ************************************************************
  // named conditions
  // ************************************************************
  // a frame wakes only in frame detection, a pattern only after a fault
  assign wuf_wake   = (swk_state == cswm_pkg::SW_WUF_DET) && bus_ev.wake_frame;
  assign wup_wake   = (swk_state == cswm_pkg::SW_WUP_DET2) && bus_ev.wake_pattern;
  assign wake_event = wuf_wake || wup_wake || ecnt_overflow;
  assign swk_arm_wr = mode_wr && reg_wdata[2] && (reg_wdata[1:0] != 2'h0);
  assign silence_restart = !in_detect || bus_ev.dominant || silence_expired;
  assign ecnt_clear  = !swk_mode || (swk_state == cswm_pkg::SW_IDLE);
  assign ecnt_freeze = swk_state == cswm_pkg::SW_WOKEN;
  // fault set only by overflow in a selective-wake mode or a mode write with bit 2 set (100 included) without cfg_ok; host clear needs cfg_ok while bit 2 is set
  assign fault_set    = (ecnt_overflow && swk_mode) || (mode_wr && reg_wdata[2] && !bus_ev.cfg_ok);
  assign fault_clr_wr = reg_wr && (reg_addr == cswm_pkg::ADDR_STATUS) &&
                        reg_wdata[cswm_pkg::STAT_FAULT_POS] &&
                        (!xcvr_mode_bit2 || bus_ev.cfg_ok);
  assign armed_set = (swk_active && (swk_state == cswm_pkg::SW_WUF_DET ||
                                     swk_state == cswm_pkg::SW_WUP_DET1)) ||
                     (selective_wake_fault_flag && swk_state == cswm_pkg::SW_WUP_DET2);
  assign tx_mode = (mode == cswm_pkg::XM_NORMAL || mode == cswm_pkg::XM_NORM_SWK) &&
                   (chip == cswm_pkg::CHIP_NORMAL);

  // ************************************************************
  // stop-entry remap
  // ************************************************************
  always_comb begin
    next_mode = mode;
    // only bit 1 clears; the top bit survives a fault
    if (mode == cswm_pkg::XM_NORMAL) begin
      next_mode = cswm_pkg::XM_WAKE;
    end else if (mode == cswm_pkg::XM_NORM_SWK) begin
      next_mode = cswm_pkg::XM_SWK;
    end
  end

  // ************************************************************
  // chip mode and mode field
  // ************************************************************
  // low-power entry does not wait for frame sync
  always_comb begin
    unique case (reg_wdata[1:0])
      2'h1:    next_chip = cswm_pkg::CHIP_STOP;
      2'h2:    next_chip = cswm_pkg::CHIP_SLEEP;
      default: next_chip = cswm_pkg::CHIP_NORMAL;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      chip <= cswm_pkg::CHIP_NORMAL;
    end else if (chip_wr) begin
      chip <= next_chip;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode <= cswm_pkg::MODE_RESET;
    end else if (mode_wr) begin
      // writes outside normal chip mode never reach here
      mode <= reg_wdata[2:0];
    end else if (to_stop) begin
      mode <= next_mode;
    end
  end

  // ************************************************************
  // selective-wake sequencer
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      swk_state <= cswm_pkg::SW_IDLE;
    end else if (!swk_mode || mode_wr) begin
      // a mode write to an enabled selective-wake code rearms the sequencer; any other mode write idles it
      if (swk_arm_wr) begin
        swk_state <= cswm_pkg::SW_WUF_DET;
      end else begin
        swk_state <= cswm_pkg::SW_IDLE;
      end
    end else begin
      unique case (swk_state)
        cswm_pkg::SW_IDLE:     swk_state <= cswm_pkg::SW_WUF_DET;
        cswm_pkg::SW_WUF_DET: begin
          if (wake_event) begin
            swk_state <= cswm_pkg::SW_WOKEN;
          end else if (silence_expired) begin
            swk_state <= selective_wake_fault_flag ? cswm_pkg::SW_WUP_DET2 : cswm_pkg::SW_WUP_DET1;
          end
        end
        cswm_pkg::SW_WUP_DET1: begin
          if (bus_ev.wake_pattern) begin
            swk_state <= cswm_pkg::SW_WUF_DET;
          end
        end
        cswm_pkg::SW_WUP_DET2: begin
          if (wake_event) begin
            swk_state <= cswm_pkg::SW_WOKEN;
          end
        end
        cswm_pkg::SW_WOKEN:    swk_state <= cswm_pkg::SW_WOKEN;
        default:               swk_state <= cswm_pkg::SW_IDLE;
      endcase
    end
  end

  // ************************************************************
  // silence timer and error counter
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      silence_timer <= 32'h0;
    end else if (silence_restart) begin
      // timer only runs in the SW_WUF_DET and SW_WUP_DET2 detection states
      silence_timer <= 32'h0;
    end else begin
      silence_timer <= silence_timer + 32'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      protocol_error_count <= 6'h0;
    end else if (ecnt_clear) begin
      protocol_error_count <= 6'h0;
    end else if (ecnt_freeze) begin
      // count is held after a wake for the host to read
      protocol_error_count <= protocol_error_count;
    end else if (ecnt_overflow) begin
      protocol_error_count <= cswm_pkg::ECNT_OVF;
    end else if (bus_ev.proto_error) begin
      protocol_error_count <= protocol_error_count + 6'h1;
    end else if (bus_ev.frame_valid && protocol_error_count != 6'h0) begin
      // a good frame steps the count back down
      protocol_error_count <= protocol_error_count - 6'h1;
    end
  end

  // ************************************************************
  // status flags
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_silence_flag <= 1'b0;
    end else if (silence_expired) begin
      // expiry wins over a pattern in the same cycle
      bus_silence_flag <= 1'b1;
    end else if (bus_ev.wake_pattern) begin
      bus_silence_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      frame_sync_flag <= 1'b0;
    end else if (!enabled) begin
      // transceiver off keeps the decoder unsynchronised
      frame_sync_flag <= 1'b0;
    end else if (bus_ev.proto_error) begin
      frame_sync_flag <= 1'b0;
    end else if (bus_ev.frame_valid) begin
      frame_sync_flag <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      selective_wake_fault_flag <= 1'b0;
    end else if (fault_set) begin
      // set beats a host clear in the same cycle
      selective_wake_fault_flag <= 1'b1;
    end else if (fault_clr_wr) begin
      selective_wake_fault_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wake_armed_flag <= 1'b0;
    end else if (!xcvr_mode_bit2 || wake_event) begin
      // a wake clears even while the arm condition still holds
      wake_armed_flag <= 1'b0;
    end else if (armed_set) begin
      wake_armed_flag <= 1'b1;
    end
  end

  // ************************************************************
  // transceiver outputs
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      receive_enable <= 1'b0;
    end else begin
      receive_enable <= xcvr_mode_bit1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_tx_enable <= 1'b0;
    end else begin
      bus_tx_enable <= tx_mode && !transmit_data_in;
    end
  end

  // receive path idles high outside receive modes, never forced low
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      receive_data_out <= 1'b1;
    end else begin
      receive_data_out <= xcvr_mode_bit1 ? bus_rx_level : 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      can_wake_irq <= 1'b0;
    end else begin
      can_wake_irq <= wake_event && chip != cswm_pkg::CHIP_SLEEP;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      xcvr_woken <= 1'b0;
    end else begin
      xcvr_woken <= swk_state == cswm_pkg::SW_WOKEN || wake_event;
    end
  end

  // ************************************************************
  // status word
  // ************************************************************
  always_comb begin
    status_word = 16'h0;
    status_word[cswm_pkg::STAT_SILENCE_POS]   = bus_silence_flag;
    status_word[cswm_pkg::STAT_SYNC_POS]      = frame_sync_flag;
    status_word[cswm_pkg::STAT_ARMED_POS]     = wake_armed_flag;
    status_word[cswm_pkg::STAT_FAULT_POS]     = selective_wake_fault_flag;
    status_word[cswm_pkg::STAT_ECNT_POS +: 6] = protocol_error_count;
  end

  // ************************************************************
  // register read
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        cswm_pkg::ADDR_MODE:   reg_rdata <= {13'h0, mode};
        cswm_pkg::ADDR_STATUS: reg_rdata <= status_word;
        cswm_pkg::ADDR_CHIP:   reg_rdata <= {14'h0, chip};
        default:               reg_rdata <= 16'h0;
      endcase
    end else begin
      reg_rdata <= 16'h0;
    end
  end

endmodule : cswm_ctrl

`default_nettype wire

// [cswm_ctrl_tb.sv]
// self-checking bench of the mode control channel
// assumes short silence count and the host model
`timescale 1ns/1ps
`default_nettype none
module cswm_ctrl_tb;
  localparam logic [3:0] AM = cswm_pkg::ADDR_MODE;
  localparam logic [3:0] AS = cswm_pkg::ADDR_STATUS;
  localparam logic [3:0] AC = cswm_pkg::ADDR_CHIP;
  localparam int SP = cswm_pkg::STAT_SILENCE_POS;
  localparam int YP = cswm_pkg::STAT_SYNC_POS;
  localparam int AP = cswm_pkg::STAT_ARMED_POS;
  localparam int FP = cswm_pkg::STAT_FAULT_POS;
  localparam int EP = cswm_pkg::STAT_ECNT_POS;
  logic                      sys_clk = 1'b0;
  logic                      sys_rst = 1'b1;
  logic [3:0]                reg_addr;
  logic [15:0]               reg_wdata;
  logic                      reg_wr;
  logic                      reg_rd;
  logic [15:0]               reg_rdata;
  cswm_pkg::cswm_bus_ev_type bus_ev = 6'h01;
  logic                      transmit_data_in = 1'b0;
  logic                      bus_rx_level = 1'b1;
  logic                      receive_data_out;
  logic                      bus_tx_enable;
  logic                      receive_enable;
  logic                      can_wake_irq;
  logic                      xcvr_woken;
  logic                      cfg = 1'b1;
  logic [15:0]               st;
  int                        miscompares = 0;
  int                        cmp_count = 0;
  int                        cyc = 0;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) bus_rx_level <= ~bus_rx_level;
  cswm_ctrl #(.SILENCE_COUNT(20)) DUT (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_ev(bus_ev),
    .transmit_data_in(transmit_data_in), .bus_rx_level(bus_rx_level),
    .receive_data_out(receive_data_out), .bus_tx_enable(bus_tx_enable),
    .receive_enable(receive_enable), .can_wake_irq(can_wake_irq), .xcvr_woken(xcvr_woken)
  );
  cswm_host host (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );
  // ****
  // helpers
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cb(input int pos, input logic exp);
    host.rd(AS, st);
    chk({15'h0, st[pos]}, {15'h0, exp});
  endtask : cb
  // one-cycle event pulse, config level kept
  task automatic ev(input logic [5:0] p);
    @(posedge sys_clk);
    bus_ev <= p | {5'h0, cfg};
    @(posedge sys_clk);
    bus_ev <= {5'h0, cfg};
  endtask : ev
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle
  task automatic final_report();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  // ****
  // scenarios
  // ****
  task automatic t_remap();
    logic [2:0] m;
    logic [2:0] x;
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      x = (m == 3'h3) ? 3'h1 : (m == 3'h7) ? 3'h5 : m;
      host.wr(AM, {13'h0, m});
      host.rd(AM, st);
      chk(st, {13'h0, m});
      host.wr(AC, 16'h1);
      host.rd(AM, st);
      chk(st, {13'h0, x});
      host.wr(AM, {13'h0, ~m});
      host.rd(AM, st);
      chk(st, {13'h0, x});
      host.wr(AC, 16'h0);
    end
  endtask : t_remap
  task automatic t_fault();
    cfg = 1'b0;
    ev(6'h00);
    host.wr(AM, 16'h0);
    host.wr(AM, 16'h7);
    cb(FP, 1'b1);
    host.wr(AS, 16'h8);
    cb(FP, 1'b1);
    host.wr(AC, 16'h1);
    host.rd(AM, st);
    chk(st, 16'h5);
    host.wr(AC, 16'h0);
    cfg = 1'b1;
    ev(6'h00);
    host.wr(AS, 16'h8);
    cb(FP, 1'b0);
  endtask : t_fault
  task automatic t_silence();
    host.wr(AM, 16'h0);
    ev(6'h20);
    host.wr(AM, 16'h5);
    cb(AP, 1'b1);
    repeat (4) begin
      ev(6'h02);
      repeat (8) @(posedge sys_clk);
    end
    cb(SP, 1'b0);
    repeat (25) @(posedge sys_clk);
    cb(SP, 1'b1);
    host.wr(AC, 16'h1);
    cb(SP, 1'b1);
    host.wr(AC, 16'h0);
    ev(6'h20);
    cb(SP, 1'b0);
    ev(6'h10);
    @(negedge sys_clk);
    chk({14'h0, can_wake_irq, xcvr_woken}, 16'h3);
    cb(AP, 1'b0);
  endtask : t_silence
  task automatic t_ovf();
    host.wr(AM, 16'h0);
    host.wr(AM, 16'h5);
    repeat (31) ev(6'h06);
    host.rd(AS, st);
    chk({10'h0, st[EP +: 6]}, {10'h0, cswm_pkg::ECNT_MAX});
    ev(6'h06);
    host.rd(AS, st);
    chk({10'h0, st[EP +: 6]}, {10'h0, cswm_pkg::ECNT_OVF});
    chk({13'h0, st[FP], st[AP], xcvr_woken}, 16'h5);
  endtask : t_ovf
  task automatic t_sync();
    host.wr(AM, 16'h2);
    ev(6'h08);
    cb(YP, 1'b1);
    ev(6'h04);
    cb(YP, 1'b0);
    chk({15'h0, bus_tx_enable}, 16'h0);
    host.wr(AM, 16'h7);
    settle();
    chk({15'h0, bus_tx_enable}, 16'h1);
    @(posedge sys_clk);
    transmit_data_in <= 1'b1;
    settle();
    chk({15'h0, bus_tx_enable}, 16'h0);
    @(posedge sys_clk);
    transmit_data_in <= 1'b0;
    host.wr(AM, 16'h6);
    settle();
    chk({15'h0, bus_tx_enable}, 16'h0);
    host.rd(4'hf, st);
    chk(st, 16'h0);
  endtask : t_sync
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_remap();
    t_fault();
    t_silence();
    t_ovf();
    t_sync();
    final_report();
  end
endmodule : cswm_ctrl_tb
`default_nettype wire

// [cswm_host.sv]
// host model driving the register port
// assumes read data stand in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module cswm_host (
  // clock
  input  wire logic        sys_clk,
  // register port
  output var  logic [3:0]  reg_addr,
  output var  logic [15:0] reg_wdata,
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  input  wire logic [15:0] reg_rdata
);
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd
endmodule : cswm_host
`default_nettype wire

// [cswm_pkg.sv]
// package for the selective-wake mode control channel
// assumes one 20 MHz system clock and a plain register port
package cswm_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [3:0] ADDR_MODE   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_CHIP   = 4'h2;

  // ************************************************************
  // field positions, reset values and error count limits
  // ************************************************************
  localparam int STAT_SILENCE_POS = 0;
  localparam int STAT_SYNC_POS    = 1;
  localparam int STAT_ARMED_POS   = 2;
  localparam int STAT_FAULT_POS   = 3;
  localparam int STAT_ECNT_POS    = 8;
  localparam logic [2:0] MODE_RESET  = 3'h0;
  localparam logic [5:0] ECNT_MAX    = 6'h1f;
  localparam logic [5:0] ECNT_OVF    = 6'h20;

  // ************************************************************
  // transceiver mode codes
  // ************************************************************
  localparam logic [2:0] XM_OFF0     = 3'h0;
  localparam logic [2:0] XM_WAKE     = 3'h1;
  localparam logic [2:0] XM_RXONLY   = 3'h2;
  localparam logic [2:0] XM_NORMAL   = 3'h3;
  localparam logic [2:0] XM_OFF1     = 3'h4;
  localparam logic [2:0] XM_SWK      = 3'h5;
  localparam logic [2:0] XM_RX_SWK   = 3'h6;
  localparam logic [2:0] XM_NORM_SWK = 3'h7;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ          = 20000000;
  localparam int SILENCE_US      = 1000;
  localparam int SILENCE_CYCLES  = SILENCE_US * (CLK_HZ / 1000000);

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {CHIP_NORMAL, CHIP_STOP, CHIP_SLEEP} cswm_chip_type;

  typedef enum logic [2:0] {
    SW_IDLE, SW_WUF_DET, SW_WUP_DET1, SW_WUP_DET2, SW_WOKEN
  } cswm_swk_state_type;

  typedef struct packed {
    logic wake_pattern;
    logic wake_frame;
    logic frame_valid;
    logic proto_error;
    logic dominant;
    logic cfg_ok;
  } cswm_bus_ev_type;

endpackage : cswm_pkg
